// *** src/sfp_flash_front.sv ***
// Serial flash pin front end: select, lane mapping, pause, write protection.
// Assumes an APB master on pclk and an SPI host driving sclk, cs_n and the lanes.
//
// Notes on behaviour
// - Select high: deselected, all lanes undriven
// - Started write cycle completes despite deselect
// - No instruction before first select falling edge
// - Single lane: input sampled on rising clock
// - Single lane: output changes on falling clock
// - Wide lanes: sample rising, drive falling
// - Four-lane operations refused without quad enable
// - Quad enable turns protect/pause pins into lanes
// - Protect pin plus status protect block status writes
// - Protect bits guard sector up to whole array
// - Pause: outputs undriven, clock and input ignored
// - Pause release resumes exactly where stopped
// - Protect and pause pins dead in quad
// - Clock modes 0 and 3 both accepted
// - Pause edges act at clock low
`timescale 1ns/1ps
`default_nettype none
`include "sfp_defs.svh"

module sfp_flash_front import sfp_pkg::*; #(
  parameter int unsigned BUSY_CYCLES = `SFP_BUSY_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] lane_in,
  output logic [3:0] lane_out,
  output logic [3:0] lane_oe
);

  // --------------------------------------------------------------------------
  // Parameter check
  // --------------------------------------------------------------------------
  if (BUSY_CYCLES < 1 || BUSY_CYCLES > 65535) begin : g_bad_busy
    $error("BUSY_CYCLES out of range");
  end
  localparam logic [15:0] BUSY_LAST = 16'(BUSY_CYCLES - 1);

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  // Register index: 0 config, 1 data, 2 state, 3 unmapped
  function automatic logic [1:0] reg_index(input logic [11:0] a);
    case (a)
      `SFP_OFF_CONFIG: reg_index = 2'h0;
      `SFP_OFF_DATA: reg_index = 2'h1;
      `SFP_OFF_STATE: reg_index = 2'h2;
      default: reg_index = 2'h3;
    endcase
  endfunction : reg_index

  // Sector protection from the configuration byte
  function automatic logic sector_protected(input sfp_cfg_s c, input logic [6:0] idx);
    logic [2:0] bp;
    logic [7:0] n;
    logic hit;
    bp = {c.block_protect_2, c.block_protect_1, c.block_protect_0};
    if (bp == 3'h0) begin
      n = 8'h00;
    end else if (c.sector_granularity_bit) begin
      n = 8'h01 << (bp - 3'h1);
    end else if (bp >= 3'h4) begin
      n = `SFP_SECTORS;
    end else begin
      n = `SFP_BLOCK_SECTORS << (bp - 3'h1);
    end
    if (c.top_bottom_select_bit) begin
      hit = {1'b0, idx} < n;
    end else begin
      hit = {1'b0, idx} >= (`SFP_SECTORS - n);
    end
    sector_protected = hit ^ c.protect_complement_bit;
  endfunction : sector_protected

  // --------------------------------------------------------------------------
  // Bus domain: pin synchronisers
  // --------------------------------------------------------------------------
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  logic armed_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_q <= 3'h7;
      pin_sync_q <= 3'h7;
    end else begin
      pin_meta_q <= {cs_n, lane_in[3], lane_in[2]};
      pin_sync_q <= pin_meta_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q <= 1'b0;
    end else if (pin_sync_q[2]) begin
      armed_q <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Bus domain: write events from the link and busy cycle
  // --------------------------------------------------------------------------
  logic evt_tgl_q;
  sfp_evt_s evt_q;
  logic [2:0] evt_sync_q;
  logic evt_fire;
  logic busy_q;
  logic [15:0] busy_cnt_q;
  sfp_cfg_s cfg_q;
  logic [7:0] data_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_sync_q <= 3'h0;
    end else begin
      evt_sync_q <= {evt_sync_q[1], evt_sync_q[0], evt_tgl_q};
    end
  end
  assign evt_fire = evt_sync_q[2] ^ evt_sync_q[1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      busy_cnt_q <= 16'h0000;
    end else if (evt_fire && !busy_q) begin
      busy_q <= 1'b1;
      busy_cnt_q <= BUSY_LAST;
    end else if (busy_q) begin
      busy_cnt_q <= busy_cnt_q - 16'h0001;
      busy_q <= (busy_cnt_q != 16'h0000);
    end
  end

  // --------------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------------
  logic setup;
  logic wr_done;

  assign setup = psel && !penable;
  assign wr_done = psel && penable && pready && pwrite && pstrb[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= `SFP_CONFIG_RESET;
    end else if (evt_fire && !busy_q && evt_q.is_status) begin
      cfg_q <= evt_q.data;
    end else if (wr_done && reg_index(paddr) == 2'h0) begin
      cfg_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= `SFP_DATA_RESET;
    end else if (wr_done && reg_index(paddr) == 2'h1) begin
      data_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && reg_index(paddr) == 2'h3;
      if (setup && !pwrite) begin
        case (reg_index(paddr))
          2'h0: prdata <= {24'h00_0000, cfg_q};
          2'h1: prdata <= {24'h00_0000, data_q};
          2'h2: begin
            prdata <= 32'h0000_0000;
            prdata[`SFP_ST_BUSY] <= busy_q;
            prdata[`SFP_ST_SELECTED] <= ~pin_sync_q[2];
            prdata[`SFP_ST_PAUSE_PIN] <= ~pin_sync_q[1];
            prdata[`SFP_ST_WP_PIN] <= pin_sync_q[0];
            prdata[`SFP_ST_ARMED] <= armed_q;
          end
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Link domain: synchronised bus-side values
  // --------------------------------------------------------------------------
  logic [16:0] lk_meta_q;
  logic [16:0] lk_sync_q;
  sfp_cfg_s cfg_lk;
  logic [7:0] data_lk;
  logic busy_lk;
  logic pause_en;

  always_ff @(posedge sclk or negedge presetn) begin
    if (!presetn) begin
      lk_meta_q <= 17'h0_0000;
      lk_sync_q <= 17'h0_0000;
    end else begin
      lk_meta_q <= {busy_q, data_q, cfg_q};
      lk_sync_q <= lk_meta_q;
    end
  end
  assign cfg_lk = lk_sync_q[7:0];
  assign data_lk = lk_sync_q[15:8];
  assign busy_lk = lk_sync_q[16];
  // Pause and protect pins only count while quad enable is clear
  assign pause_en = ~cfg_lk.quad_enable_bit;

  // --------------------------------------------------------------------------
  // Link domain: instruction intake on rising clock
  // --------------------------------------------------------------------------
  logic link_rst;
  logic started_q;
  sfp_state_e state_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] sh_q;
  logic [7:0] sh_d;
  logic prog_q;
  logic rd_q;
  logic rd_status_q;
  sfp_width_e width_q;
  logic pause_rise;
  logic byte_done;
  logic go_status;
  logic go_prog;

  assign link_rst = ~presetn | cs_n;

  // Set by select high, so a frame already running at reset is refused
  always_ff @(posedge sclk or negedge presetn or posedge cs_n) begin
    if (!presetn) begin
      started_q <= 1'b0;
    end else if (cs_n) begin
      started_q <= 1'b1;
    end else begin
      started_q <= started_q;
    end
  end

  always_comb begin
    // Rising edge seen while pause pin low: clock was low at or after the pause edge
    pause_rise = pause_en & ~lane_in[3];
    sh_d = {sh_q[6:0], lane_in[0]};
    byte_done = !pause_rise && bit_cnt_q == 3'h7;
    go_status = byte_done && state_q == SFP_ST_WDATA;
    go_prog = byte_done && state_q == SFP_ST_ADDR && prog_q && !busy_lk
              && !sector_protected(cfg_lk, sh_d[6:0]);
  end

  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      state_q <= SFP_ST_CMD;
      bit_cnt_q <= 3'h0;
      sh_q <= 8'h00;
      prog_q <= 1'b0;
      rd_q <= 1'b0;
      rd_status_q <= 1'b0;
      width_q <= SFP_W1;
    end else if (!pause_rise) begin
      sh_q <= sh_d;
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (byte_done) begin
        case (state_q)
          SFP_ST_CMD: begin
            state_q <= SFP_ST_IGNORE;
            if (started_q) begin
              case (sh_d)
                `SFP_CMD_RD_STATUS: begin
                  state_q <= SFP_ST_READ;
                  rd_q <= 1'b1;
                  rd_status_q <= 1'b1;
                end
                `SFP_CMD_RD_DATA: state_q <= SFP_ST_ADDR;
                `SFP_CMD_RD_DUAL: begin
                  state_q <= SFP_ST_ADDR;
                  width_q <= SFP_W2;
                end
                `SFP_CMD_RD_QUAD: begin
                  if (cfg_lk.quad_enable_bit) begin
                    state_q <= SFP_ST_ADDR;
                    width_q <= SFP_W4;
                  end
                end
                `SFP_CMD_WR_STATUS: begin
                  if (!busy_lk && !(cfg_lk.status_protect_bit && pause_en
                                    && !lane_in[2])) begin
                    state_q <= SFP_ST_WDATA;
                  end
                end
                `SFP_CMD_PROGRAM: begin
                  if (!busy_lk) begin
                    state_q <= SFP_ST_ADDR;
                    prog_q <= 1'b1;
                  end
                end
                default: state_q <= SFP_ST_IGNORE;
              endcase
            end
          end
          SFP_ST_ADDR: begin
            if (prog_q) begin
              state_q <= SFP_ST_IGNORE;
            end else begin
              state_q <= SFP_ST_READ;
              rd_q <= 1'b1;
            end
          end
          SFP_ST_WDATA: state_q <= SFP_ST_IGNORE;
          SFP_ST_READ: state_q <= SFP_ST_READ;
          SFP_ST_IGNORE: state_q <= SFP_ST_IGNORE;
          default: state_q <= SFP_ST_IGNORE;
        endcase
      end
    end
  end

  // Event payload survives deselect until the bus domain takes it
  always_ff @(posedge sclk or negedge presetn) begin
    if (!presetn) begin
      evt_tgl_q <= 1'b0;
      evt_q <= '0;
    end else if (go_status || go_prog) begin
      evt_tgl_q <= ~evt_tgl_q;
      evt_q <= '{is_status: go_status, data: sh_d};
    end
  end

  // --------------------------------------------------------------------------
  // Link domain: output lanes on falling clock
  // --------------------------------------------------------------------------
  logic pause_fall;
  logic oe_clr;
  logic [7:0] out_sr_q;
  logic [3:0] out_cnt_q;
  logic out_first_q;
  logic [7:0] cur;
  logic [3:0] step;
  logic [3:0] oe_mask;

  always_comb begin
    pause_fall = pause_en & ~lane_in[3];
    oe_clr = link_rst | pause_fall;
    cur = (out_first_q || out_cnt_q == 4'h0) ? (rd_status_q ? cfg_lk : data_lk) : out_sr_q;
    case (width_q)
      SFP_W2: begin
        step = 4'h2;
        oe_mask = 4'b0011;
      end
      SFP_W4: begin
        step = 4'h4;
        oe_mask = 4'b1111;
      end
      default: begin
        step = 4'h1;
        oe_mask = 4'b0010;
      end
    endcase
  end

  always_ff @(negedge sclk or posedge link_rst) begin
    if (link_rst) begin
      out_sr_q <= 8'h00;
      out_cnt_q <= 4'h0;
      out_first_q <= 1'b1;
      lane_out <= 4'h0;
    end else if (rd_q && !pause_fall) begin
      out_first_q <= 1'b0;
      out_sr_q <= cur << step;
      out_cnt_q <= (out_first_q || out_cnt_q == 4'h0) ? 4'h8 - step : out_cnt_q - step;
      case (width_q)
        SFP_W2: lane_out <= {2'b00, cur[7:6]};
        SFP_W4: lane_out <= cur[7:4];
        default: lane_out <= {2'b00, cur[7], 1'b0};
      endcase
    end
  end

  always_ff @(negedge sclk or posedge oe_clr) begin
    if (oe_clr) begin
      lane_oe <= 4'h0;
    end else begin
      lane_oe <= rd_q ? oe_mask : 4'h0;
    end
  end

endmodule : sfp_flash_front
`default_nettype wire

// *** src/sfp_defs.svh ***
// Constants for the serial flash pin front end: offsets, reset values, codes, timing.
// Assumes inclusion by bare name from the top module.
`ifndef SFP_DEFS_SVH
`define SFP_DEFS_SVH
// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define SFP_OFF_CONFIG 12'h000
`define SFP_OFF_DATA 12'h004
`define SFP_OFF_STATE 12'h008
`define SFP_CONFIG_RESET 8'h00
`define SFP_DATA_RESET 8'h00
// ----------------------------------------------------------------------------
// State register bit positions
// ----------------------------------------------------------------------------
`define SFP_ST_BUSY 0
`define SFP_ST_SELECTED 1
`define SFP_ST_PAUSE_PIN 2
`define SFP_ST_WP_PIN 3
`define SFP_ST_ARMED 4
// ----------------------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------------------
`define SFP_CMD_WR_STATUS 8'h01
`define SFP_CMD_PROGRAM 8'h02
`define SFP_CMD_RD_DATA 8'h03
`define SFP_CMD_RD_STATUS 8'h05
`define SFP_CMD_RD_DUAL 8'h3B
`define SFP_CMD_RD_QUAD 8'h6B
// ----------------------------------------------------------------------------
// Array geometry and timing
// ----------------------------------------------------------------------------
`define SFP_SECTORS 8'h80
`define SFP_BLOCK_SECTORS 8'h10
`define SFP_PCLK_MHZ 200
`define SFP_BUSY_NS 320
`define SFP_BUSY_CYCLES ((`SFP_BUSY_NS * `SFP_PCLK_MHZ + 999) / 1000)
`endif

// *** src/sfp_pkg.sv ***
// Types shared by the serial flash pin front end.
// Assumes sfp_defs.svh is on the include path.
package sfp_pkg;
  // --------------------------------------------------------------------------
  // Protection and lane configuration byte
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic protect_complement_bit;
    logic sector_granularity_bit;
    logic top_bottom_select_bit;
    logic block_protect_2;
    logic block_protect_1;
    logic block_protect_0;
    logic status_protect_bit;
    logic quad_enable_bit;
  } sfp_cfg_s;

  // Write event handed from link to bus domain
  typedef struct packed {
    logic is_status;
    logic [7:0] data;
  } sfp_evt_s;

  typedef enum logic [4:0] {
    SFP_ST_CMD = 5'b00001,
    SFP_ST_ADDR = 5'b00010,
    SFP_ST_WDATA = 5'b00100,
    SFP_ST_READ = 5'b01000,
    SFP_ST_IGNORE = 5'b10000
  } sfp_state_e;

  typedef enum logic [1:0] {
    SFP_W1 = 2'h0,
    SFP_W2 = 2'h1,
    SFP_W4 = 2'h2
  } sfp_width_e;
endpackage : sfp_pkg

// *** tb/sfp_flash_front_chk.sv ***
// Port checker for the serial flash pin front end.
// Assumes a bind to sfp_flash_front; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module sfp_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] lane_in,
  input wire logic [3:0] lane_out,
  input wire logic [3:0] lane_oe
);
  logic armed_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q <= 1'b0;
    end else if (cs_n) begin
      armed_q <= 1'b1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_pause;
    !cs_n && sclk && $fell(lane_in[3]) && lane_oe != 4'hF;
  endsequence
  a_ready_next: assert property (s_setup |=> pready ##1 !pready)
    else $error("pready not a pulse after setup");
  a_err_unmapped: assert property (pready && !(paddr inside {12'h000, 12'h004, 12'h008})
    |-> pslverr && prdata == 32'h0000_0000) else $error("unmapped access not refused");
  a_deselect_hiz: assert property (cs_n |-> lane_oe == 4'h0)
    else $error("lanes driven while deselected");
  a_armed_first: assert property (!armed_q |-> lane_oe == 4'h0)
    else $error("lanes driven before first select");
  a_out_on_fall: assert property (!cs_n && $changed(lane_out) |-> !sclk)
    else $error("output changed off falling clock");
  a_oe_on_fall: assert property (!cs_n && lane_oe != 4'h0 && $changed(lane_oe) |-> !sclk)
    else $error("drivers enabled off falling clock");
  a_oe_shape: assert property (lane_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("illegal lane enable pattern");
  a_pause_hiz: assert property (s_pause |=> (lane_oe == 4'h0) [*4])
    else $error("lanes driven during pause");
endmodule : sfp_chk
bind sfp_flash_front sfp_chk sfp_chk_inst (.pclk, .presetn, .paddr, .psel, .penable, .prdata,
  .pready, .pslverr, .sclk, .cs_n, .lane_in, .lane_out, .lane_oe);
`default_nettype wire

// *** tb/sfp_host_model.sv ***
// SPI host model: clock, select and lane wires of the flash front end.
// Assumes frame() is called just after a pclk edge.
`timescale 1ns/1ps
`default_nettype none
module sfp_host_model (
  input wire logic [3:0] lane_out,
  input wire logic [3:0] lane_oe,
  output logic sclk,
  output logic cs_n,
  output logic [3:0] lane_in
);
  logic [3:0] h_oe;
  logic [3:0] h_out;
  logic d_q;
  logic junk_q;
  logic wp_n;
  logic hold_n;
  logic oe_any;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b0;
    h_oe = 4'hD;
    d_q = 1'b0;
    junk_q = 1'b0;
    wp_n = 1'b1;
    hold_n = 1'b1;
    oe_any = 1'b0;
  end
  always @(posedge sclk) junk_q <= ~junk_q;
  assign h_out = {hold_n, wp_n, 1'b0, d_q};
  // Wire level: device, host, else pull-up or junk
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane_in[i] = lane_oe[i] ? lane_out[i] : h_oe[i] ? h_out[i] : (i > 1 || junk_q);
    end
  end
  task automatic frame(input logic [7:0] cmd, input logic [7:0] arg, input int na,
    input int w, input logic m3, input int pa, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, arg};
    rd = 8'h00;
    oe_any = 1'b0;
    sclk = m3;
    #2;
    cs_n = 1'b0;
    h_oe = 4'hD;
    for (int i = 0; i < 8 + 8 * na + 8 / w; i++) begin
      // Pause entered and left with clock high, so both act at a falling edge
      if (i == pa) begin
        hold_n = 1'b0;
        repeat (2) begin
          #15 sclk = 1'b0;
          #15 sclk = 1'b1;
        end
        hold_n = 1'b1;
        #15;
      end
      sclk = 1'b0;
      if (i == 8 + 8 * na) h_oe = (w == 1) ? 4'hD : (w == 2) ? 4'hC : 4'h0;
      d_q = sh[15];
      sh = sh << 1;
      #15 sclk = 1'b1;
      oe_any = oe_any | (|lane_oe);
      rd = (w == 1) ? {rd[6:0], lane_in[1]} : (w == 2) ? {rd[5:0], lane_in[1:0]} :
        {rd[3:0], lane_in};
      #15;
    end
    sclk = m3;
    #15 cs_n = 1'b1;
    #30;
  endtask : frame
endmodule : sfp_host_model
`default_nettype wire

// *** tb/serial_flash_pin_interface_test.sv ***
// Self-checking bench for the serial flash pin front end.
// Assumes sfp_flash_front, its checker and the SPI host model.
`timescale 1ns/1ps
`default_nettype none
module serial_flash_pin_interface_test;
  logic pclk;
  logic presetn;
  logic [11:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sclk;
  logic cs_n;
  logic [3:0] lane_in;
  logic [3:0] lane_out;
  logic [3:0] lane_oe;
  int err_count;
  int check_count;
  int cyc;
  sfp_flash_front #(.BUSY_CYCLES(48)) sfp_flash_front_inst (.pclk, .presetn, .paddr, .psel,
    .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .sclk, .cs_n, .lane_in,
    .lane_out, .lane_oe);
  sfp_host_model sfp_host_model_inst (.lane_out, .lane_oe, .sclk, .cs_n, .lane_in);
  task automatic stop_test();
    if (err_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd,
    output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e,
    input logic ee);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 8'h00, rd, err);
    chk(32'(rd[7:0] & m), 32'(e));
    chk(32'(err), 32'(ee));
  endtask : rdc
  task automatic spi(input logic [7:0] c, input logic [7:0] ar, input int na, input int w,
    input logic m3, input int pa, input logic [7:0] e, input logic oe);
    logic [7:0] rd;
    sfp_host_model_inst.frame(c, ar, na, w, m3, pa, rd);
    chk(32'(sfp_host_model_inst.oe_any), 32'(oe));
    if (oe) chk(32'(rd), 32'(e));
    @(posedge pclk);
  endtask : spi
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    err_count = 0;
    check_count = 0;
    cyc = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(12'h000, 8'hFF, 8'h00, 1'b0);
    rdc(12'h004, 8'hFF, 8'h00, 1'b0);
    rdc(12'h00C, 8'hFF, 8'h00, 1'b1);
    wr(12'h000, 8'hA6);
    wr(12'h004, 8'h5A);
    spi(8'h05, 8'h00, 0, 1, 1'b0, -1, 8'h00, 1'b0);
    spi(8'h05, 8'h00, 0, 1, 1'b0, -1, 8'hA6, 1'b1);
    spi(8'h05, 8'h00, 0, 1, 1'b1, -1, 8'hA6, 1'b1);
    spi(8'h05, 8'h00, 0, 1, 1'b0, 11, 8'hA6, 1'b1);
    spi(8'h03, 8'h00, 1, 1, 1'b0, -1, 8'h5A, 1'b1);
    spi(8'h3B, 8'h00, 1, 2, 1'b1, -1, 8'h5A, 1'b1);
    spi(8'h6B, 8'h00, 1, 4, 1'b0, -1, 8'h00, 1'b0);
    sfp_host_model_inst.wp_n = 1'b0;
    spi(8'h01, 8'h00, 1, 4, 1'b0, -1, 8'h00, 1'b0);
    rdc(12'h000, 8'hFF, 8'hA6, 1'b0);
    wr(12'h000, 8'hA7);
    spi(8'h6B, 8'h00, 1, 4, 1'b0, -1, 8'h5A, 1'b1);
    spi(8'h01, 8'h04, 1, 4, 1'b0, -1, 8'h00, 1'b0);
    rdc(12'h008, 8'h01, 8'h01, 1'b0);
    repeat (70) @(posedge pclk);
    rdc(12'h000, 8'hFF, 8'h04, 1'b0);
    for (int i = 0; i < 2; i++) begin
      spi(8'h02, 8'(8'h70 - i), 1, 4, 1'b0, -1, 8'h00, 1'b0);
      rdc(12'h008, 8'h01, 8'(i), 1'b0);
      repeat (70) @(posedge pclk);
    end
    stop_test();
  end
endmodule : serial_flash_pin_interface_test
`default_nettype wire
